//--- hdl/lcram_cell.sv
// logic cell whose two lookup tables serve as distributed memory
// assumes fabric logic drives addresses, data and write enable synchronously
// to clock, and software sets the arrangement over the plain register port
//
// Contract
// - as two 16x1 memories the cell has two data inputs and two outputs, shared or own addresses.
// - as one 32x1 memory the cell has exactly one data input and one data output.
// - one table may be a 16x1 memory while the rest forms any function of up to five inputs.
// - in synchronous mode data is stored only on the clock edge, write enable acting as enable.
// - in asynchronous mode the memory writes while the outside write strobe is active; the code refuses it in dual port use, which stays synchronous.
// - one chosen timing mode governs both tables when both are memory.
// - in single port use each table reads and writes through one shared address.
// - in dual port use both tables form one 16x1 memory with one write and two read ports.
// - the dual port memory allows read and write in one cycle, same address or not.
// - reads are combinational and need no clock.
// - in memory mode the three auxiliary inputs become two write data inputs and write enable.
// - in the 32x1 arrangement the second data input is address bit four, the first the data.
// - addressed contents appear on the table outputs, directly or through the cell flip-flops.
//
// Our own choices: the address-and-strobe port and the address map.
`timescale 1ns/100ps
module lcram_cell import lcram_pkg::*; #(
	parameter int ADDR_BITS = LCRAM_ADDR_BITS,
	parameter int TRUTH_BITS = LCRAM_TRUTH_BITS
) (
	// clock and reset
	input wire logic clock,
	input wire logic reset,
	// table address inputs from fabric
	input wire logic [ADDR_BITS-1:0] first_table_address,
	input wire logic [ADDR_BITS-1:0] second_table_address,
	// auxiliary control inputs
	input wire logic aux_input_zero,
	input wire logic aux_input_one,
	input wire logic aux_input_two,
	// table outputs, direct
	output logic first_data,
	output logic second_data,
	// table outputs through the cell flip-flops
	output logic first_data_q,
	output logic second_data_q,
	// register port
	input wire logic [LCRAM_REG_ADDR_BITS-1:0] reg_addr,
	input wire logic [LCRAM_REG_DATA_BITS-1:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [LCRAM_REG_DATA_BITS-1:0] reg_rdata
);

	// refuse geometries that the routing below cannot serve
	if (ADDR_BITS != LCRAM_ADDR_BITS) begin : g_bad_addr
		$error("lcram_cell: ADDR_BITS must be 4");
	end
	if (TRUTH_BITS != (2 << LCRAM_ADDR_BITS)) begin : g_bad_truth
		$error("lcram_cell: TRUTH_BITS must be 32");
	end

	// registered state of the cell apart from the two table contents
	typedef struct packed {
		lcram_cfg_t cfg;
		logic [TRUTH_BITS-1:0] truth;
		logic [LCRAM_REG_DATA_BITS-1:0] rdata;
		logic first_q;
		logic second_q;
	} lcram_cell_st_t;

	lcram_cell_st_t st_q;
	lcram_cell_st_t st_d;

	// auxiliary inputs renamed for memory use
	logic write_enable;
	logic write_data_low;
	logic write_data_high_or_addr4;

	// effective timing and refused request
	logic async_eff;
	logic async_refused;

	// table write requests and read addresses
	lcram_wr_t first_wr;
	lcram_wr_t second_wr;
	logic [ADDR_BITS-1:0] first_raddr;
	logic [ADDR_BITS-1:0] second_raddr;
	logic first_rd;
	logic second_rd;
	logic first_comb;
	logic second_comb;
	logic [4:0] logic_index;

	// auxiliary lines take their memory meaning
	assign write_data_low = aux_input_two;
	assign write_data_high_or_addr4 = aux_input_one;
	assign write_enable = aux_input_zero;

	// dual port refuses strobe writes; one mode covers both tables
	assign async_refused = st_q.cfg.async_mode && (st_q.cfg.arr == LCRAM_ARR_DUAL_16X1);
	assign async_eff = st_q.cfg.async_mode && !async_refused;

	// route addresses and write data per arrangement
	always_comb begin
		first_wr = '0;
		second_wr = '0;
		first_raddr = first_table_address;
		second_raddr = second_table_address;
		logic_index = {write_data_high_or_addr4, second_table_address};
		case (st_q.cfg.arr)
			LCRAM_ARR_TWO_16X1: begin
				// each table reads and writes at its own single address
				first_wr.we = write_enable;
				first_wr.addr = first_table_address;
				first_wr.data = write_data_low;
				second_wr.we = write_enable;
				second_wr.addr = second_table_address;
				second_wr.data = write_data_high_or_addr4;
			end
			LCRAM_ARR_ONE_32X1: begin
				// fifth address bit picks the table; both see the first address
				first_wr.we = write_enable && !write_data_high_or_addr4;
				first_wr.addr = first_table_address;
				first_wr.data = write_data_low;
				second_wr.we = write_enable && write_data_high_or_addr4;
				second_wr.addr = first_table_address;
				second_wr.data = write_data_low;
				second_raddr = first_table_address;
			end
			LCRAM_ARR_DUAL_16X1: begin
				// same word lands in both tables; second read port is independent
				first_wr.we = write_enable;
				first_wr.addr = first_table_address;
				first_wr.data = write_data_low;
				second_wr.we = write_enable;
				second_wr.addr = first_table_address;
				second_wr.data = write_data_low;
			end
			LCRAM_ARR_RAM_LOGIC: begin
				// first table is memory, second table idle
				first_wr.we = write_enable;
				first_wr.addr = first_table_address;
				first_wr.data = write_data_low;
			end
			default: begin
				first_wr = '0;
			end
		endcase
	end

	// the two lookup tables
	lcram_table #(
		.DEPTH(LCRAM_DEPTH)
	) u_first_table (
		.clock(clock),
		.reset(reset),
		.wr(first_wr),
		.transparent(async_eff),
		.raddr(first_raddr),
		.rdata(first_rd)
	);

	lcram_table #(
		.DEPTH(LCRAM_DEPTH)
	) u_second_table (
		.clock(clock),
		.reset(reset),
		.wr(second_wr),
		.transparent(async_eff),
		.raddr(second_raddr),
		.rdata(second_rd)
	);

	// select what each output shows
	always_comb begin
		case (st_q.cfg.arr)
			LCRAM_ARR_ONE_32X1: begin
				first_comb = write_data_high_or_addr4 ? second_rd : first_rd;
				second_comb = 1'b0;
			end
			LCRAM_ARR_RAM_LOGIC: begin
				first_comb = first_rd;
				second_comb = st_q.truth[logic_index];
			end
			default: begin
				first_comb = first_rd;
				second_comb = second_rd;
			end
		endcase
	end

	// direct exits leave the cell without a clock
	assign first_data = first_comb;
	assign second_data = second_comb;

	// next state: register port, cell flip-flops, read data
	always_comb begin
		st_d = st_q;
		// cell flip-flops capture the table outputs when enabled
		if (st_q.cfg.reg_out) begin
			st_d.first_q = first_comb;
			st_d.second_q = second_comb;
		end
		// software writes
		if (reg_write) begin
			case (reg_addr)
				LCRAM_REG_CONFIG: begin
					st_d.cfg.arr = lcram_arr_t'(reg_wdata[LCRAM_CFG_ARR_LSB +: 2]);
					st_d.cfg.async_mode = reg_wdata[LCRAM_CFG_ASYNC_BIT];
					st_d.cfg.reg_out = reg_wdata[LCRAM_CFG_REGOUT_BIT];
				end
				LCRAM_REG_TRUTH: begin
					st_d.truth = reg_wdata[TRUTH_BITS-1:0];
				end
				default: begin
					st_d.truth = st_q.truth; // status and unmapped ignore writes
				end
			endcase
		end
		// read data stands in the cycle after the strobe only
		st_d.rdata = LCRAM_ZERO_WORD;
		if (reg_read) begin
			case (reg_addr)
				LCRAM_REG_CONFIG: begin
					st_d.rdata[LCRAM_CFG_ARR_LSB +: 2] = st_q.cfg.arr;
					st_d.rdata[LCRAM_CFG_ASYNC_BIT] = st_q.cfg.async_mode;
					st_d.rdata[LCRAM_CFG_REGOUT_BIT] = st_q.cfg.reg_out;
				end
				LCRAM_REG_TRUTH: begin
					st_d.rdata[TRUTH_BITS-1:0] = st_q.truth;
				end
				LCRAM_REG_STATUS: begin
					st_d.rdata[LCRAM_ST_FIRST_BIT] = first_comb;
					st_d.rdata[LCRAM_ST_SECOND_BIT] = second_comb;
					st_d.rdata[LCRAM_ST_REFUSED_BIT] = async_refused;
					st_d.rdata[LCRAM_ST_FIRST_Q_BIT] = st_q.first_q;
					st_d.rdata[LCRAM_ST_SECOND_Q_BIT] = st_q.second_q;
				end
				default: begin
					st_d.rdata = LCRAM_ZERO_WORD; // unmapped reads as zero
				end
			endcase
		end
	end

	// register the whole state
	always_ff @(posedge clock) begin
		if (reset) begin
			st_q.cfg <= LCRAM_CFG_RESET;
			st_q.truth <= LCRAM_TRUTH_RESET;
			st_q.rdata <= LCRAM_ZERO_WORD;
			st_q.first_q <= 1'b0;
			st_q.second_q <= 1'b0;
		end else begin
			st_q <= st_d;
		end
	end

	// registered outputs
	assign first_data_q = st_q.first_q;
	assign second_data_q = st_q.second_q;
	assign reg_rdata = st_q.rdata;

endmodule

//--- common/lcram_pkg.sv
// shared constants and types for the logic cell distributed memory
// assumes one 100 MHz clock and a synchronous active high reset
package lcram_pkg;

	// table geometry
	localparam int LCRAM_ADDR_BITS = 4;
	localparam int LCRAM_DEPTH = 16;
	localparam int LCRAM_TRUTH_BITS = 32;

	// register port geometry
	localparam int LCRAM_REG_ADDR_BITS = 2;
	localparam int LCRAM_REG_DATA_BITS = 32;

	// register offsets (word index on the plain register port)
	localparam logic [1:0] LCRAM_REG_CONFIG = 2'h0;
	localparam logic [1:0] LCRAM_REG_TRUTH = 2'h1;
	localparam logic [1:0] LCRAM_REG_STATUS = 2'h2;

	// config register field positions
	localparam int LCRAM_CFG_ARR_LSB = 0;
	localparam int LCRAM_CFG_ASYNC_BIT = 2;
	localparam int LCRAM_CFG_REGOUT_BIT = 3;

	// status register field positions
	localparam int LCRAM_ST_FIRST_BIT = 0;
	localparam int LCRAM_ST_SECOND_BIT = 1;
	localparam int LCRAM_ST_REFUSED_BIT = 2;
	localparam int LCRAM_ST_FIRST_Q_BIT = 3;
	localparam int LCRAM_ST_SECOND_Q_BIT = 4;

	// reset values
	localparam logic [31:0] LCRAM_TRUTH_RESET = 32'h0000_0000;
	localparam logic [31:0] LCRAM_ZERO_WORD = 32'h0000_0000;

	// memory arrangement of the cell
	typedef enum logic [1:0] {
		LCRAM_ARR_TWO_16X1,
		LCRAM_ARR_ONE_32X1,
		LCRAM_ARR_DUAL_16X1,
		LCRAM_ARR_RAM_LOGIC
	} lcram_arr_t;

	// configuration carried as one unit
	typedef struct packed {
		lcram_arr_t arr;
		logic async_mode;
		logic reg_out;
	} lcram_cfg_t;

	localparam lcram_cfg_t LCRAM_CFG_RESET = '{arr: LCRAM_ARR_TWO_16X1, async_mode: 1'b0,
		reg_out: 1'b0};

	// write request into one table
	typedef struct packed {
		logic we;
		logic [3:0] addr;
		logic data;
	} lcram_wr_t;

endpackage

//--- hdl/lcram_table.sv
// one 16x1 lookup table used as memory: one write port, one combinational read port
// assumes the parent shapes the write request and picks the timing mode
`timescale 1ns/100ps
module lcram_table import lcram_pkg::*; #(
	parameter int DEPTH = LCRAM_DEPTH
) (
	// clock and reset
	input wire logic clock,
	input wire logic reset,
	// write port
	input wire lcram_wr_t wr,
	input wire logic transparent,
	// read port
	input wire logic [LCRAM_ADDR_BITS-1:0] raddr,
	output logic rdata
);

	// refuse a depth that the four address bits cannot reach
	if (DEPTH != (1 << LCRAM_ADDR_BITS)) begin : g_bad_depth
		$error("lcram_table: DEPTH must match address width");
	end

	typedef struct packed {
		logic [DEPTH-1:0] bits;
	} lcram_tab_st_t;

	lcram_tab_st_t st_q;
	lcram_tab_st_t st_d;

	// store on the clock edge only while write enable is high
	always_comb begin
		st_d = st_q;
		if (wr.we) begin
			st_d.bits[wr.addr] = wr.data;
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	// read needs no clock; a level strobe write shows through at once
	always_comb begin
		if (transparent && wr.we && (wr.addr == raddr)) begin
			rdata = wr.data;
		end else begin
			rdata = st_q.bits[raddr];
		end
	end

endmodule

//--- test/lcram_cell_sva.sv
// port assertions for the logic cell memory, bound into lcram_cell
// assumes one clock and a synchronous active high reset
`timescale 1ns/100ps
module lcram_cell_sva import lcram_pkg::*; (
	// clock and reset
	input wire logic clock,
	input wire logic reset,
	// fabric pins
	input wire logic [3:0] first_table_address,
	input wire logic [3:0] second_table_address,
	input wire logic aux_input_zero,
	input wire logic aux_input_one,
	input wire logic aux_input_two,
	input wire logic first_data,
	input wire logic second_data,
	input wire logic first_data_q,
	input wire logic second_data_q,
	// register port
	input wire logic [1:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_write
);
	logic [1:0] arr_q;
	logic async_q, regout_q;
	logic [31:0] truth_q;
	default clocking cb @(posedge clock); endclocking
	default disable iff (reset);
	// shadow of the config and truth registers
	always_ff @(posedge clock) begin
		if (reset) begin
			{regout_q, async_q, arr_q} <= 4'h0;
			truth_q <= 32'h0000_0000;
		end else if (reg_write && reg_addr == LCRAM_REG_CONFIG) begin
			{regout_q, async_q, arr_q} <= reg_wdata[3:0];
		end else if (reg_write && reg_addr == LCRAM_REG_TRUTH) begin
			truth_q <= reg_wdata;
		end
	end
	property p_sync_write;
		aux_input_zero ##1 (!aux_input_zero && $stable(first_table_address)
			&& $stable(aux_input_one) && $stable(arr_q)) |-> first_data == $past(aux_input_two);
	endproperty
	a_sync_write: assert property (p_sync_write) else $error("stored bit not read back");
	property p_we_enable;
		!aux_input_zero ##1 (!aux_input_zero && $stable(first_table_address)
			&& $stable(aux_input_one) && $stable(arr_q)) |-> $stable(first_data);
	endproperty
	a_we_enable: assert property (p_we_enable) else $error("content changed without enable");
	property p_async_pass;
		async_q && arr_q == 2'h0 && aux_input_zero |->
			first_data == aux_input_two && second_data == aux_input_one;
	endproperty
	a_async_pass: assert property (p_async_pass) else $error("strobe write not passed through");
	property p_two_second;
		arr_q == 2'h0 && aux_input_zero ##1 (!aux_input_zero && $stable(second_table_address)
			&& $stable(arr_q)) |-> second_data == $past(aux_input_one);
	endproperty
	a_two_second: assert property (p_two_second) else $error("second table write lost");
	property p_one_out;
		arr_q == 2'h1 |-> second_data == 1'b0;
	endproperty
	a_one_out: assert property (p_one_out) else $error("second output active in 32x1");
	property p_logic_fn;
		arr_q == 2'h3 |-> second_data == truth_q[{aux_input_one, second_table_address}];
	endproperty
	a_logic_fn: assert property (p_logic_fn) else $error("logic function output wrong");
	property p_dual_ports;
		arr_q == 2'h2 && first_table_address == second_table_address |-> first_data == second_data;
	endproperty
	a_dual_ports: assert property (p_dual_ports) else $error("read ports disagree");
	property p_q_load;
		regout_q |=> first_data_q == $past(first_data) && second_data_q == $past(second_data);
	endproperty
	a_q_load: assert property (p_q_load) else $error("cell flops did not load");
	c_one: cover property (arr_q == 2'h1 && aux_input_zero);
	c_async: cover property (async_q && aux_input_zero);
	c_dual: cover property (arr_q == 2'h2 && first_table_address == second_table_address);
endmodule
bind lcram_cell lcram_cell_sva u_lcram_cell_sva (.clock(clock), .reset(reset),
	.first_table_address(first_table_address), .second_table_address(second_table_address),
	.aux_input_zero(aux_input_zero), .aux_input_one(aux_input_one),
	.aux_input_two(aux_input_two), .first_data(first_data), .second_data(second_data),
	.first_data_q(first_data_q), .second_data_q(second_data_q), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_write(reg_write));

//--- test/lcram_fabric.sv
// fabric logic model that drives the memory pins of the cell
// assumes the bench hands it the next pin values each cycle
`timescale 1ns/100ps
module lcram_fabric (
	// clock
	input wire logic clock,
	// next pin values {first addr, second addr, enable, aux one, aux two}
	input wire logic [10:0] next_pins,
	// pins of the cell
	output logic [10:0] pins = 11'h000
);
	// launch all pins together after the edge, strobe one cycle per write
	always @(posedge clock) begin
		pins <= next_pins;
	end
endmodule

//--- test/lcram_cell_tb.sv
// self-checking bench for the logic cell memory, random pins from a fixed seed
// assumes the fabric model and the bound checker are compiled with it
`timescale 1ns/100ps
module lcram_cell_tb import lcram_pkg::*;;
	logic clock = 1'b0;
	logic reset = 1'b1;
	logic [10:0] next_pins = 11'h000;
	logic [10:0] pins;
	logic [3:0] fa, sa;
	logic we, d1, d0, fd, sd;
	logic fq, sq, pf, ps;
	logic [1:0] reg_addr = 2'h0;
	logic [31:0] reg_wdata = 32'h0000_0000;
	logic [31:0] reg_rdata, rv;
	logic reg_write = 1'b0;
	logic reg_read = 1'b0;
	logic [15:0] m0, m1;
	logic [31:0] truth_m = 32'h0000_0000;
	logic [31:0] seed = 32'h0000_a03e;
	logic [1:0] arr_m = 2'h0;
	logic async_m = 1'b0;
	logic regout_m = 1'b0;
	int failures = 0;
	int samples_checked = 0;
	int cycles = 0;
	always #5 clock = ~clock;
	assign {fa, sa, we, d1, d0} = pins;
	lcram_fabric u_lcram_fabric (.clock(clock), .next_pins(next_pins), .pins(pins));
	lcram_cell u_lcram_cell (.clock(clock), .reset(reset), .first_table_address(fa),
		.second_table_address(sa), .aux_input_zero(we), .aux_input_one(d1),
		.aux_input_two(d0), .first_data(fd), .second_data(sd), .first_data_q(fq),
		.second_data_q(sq), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata));
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction
	// expected outputs from the reference tables and the pins
	function automatic logic exp_first();
		if (async_m && arr_m != 2'h2 && we) return d0;
		if (arr_m == 2'h1 && d1) return m1[fa];
		return m0[fa];
	endfunction
	function automatic logic exp_second();
		case (arr_m)
			2'h0: return (async_m && we) ? d1 : m1[sa];
			2'h1: return 1'b0;
			2'h2: return m1[sa];
			default: return truth_m[{d1, sa}];
		endcase
	endfunction
	// reference tables, written at the edge that sees the enable
	always @(posedge clock) begin
		if (reset) begin
			m0 = 16'h0000;
			m1 = 16'h0000;
		end else if (we) begin
			if (arr_m == 2'h1 && d1)
				m1[fa] = d0;
			else
				m0[fa] = d0;
			if (arr_m == 2'h0)
				m1[sa] = d1;
			else if (arr_m == 2'h2)
				m1[fa] = d0;
		end
	end
	task automatic stop_test();
		$display("checks %0d mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// cut a hang short
	always @(posedge clock) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			stop_test();
		end
	end
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic reg_wr(input logic [1:0] a, input logic [31:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge clock);
		reg_write <= 1'b0;
		if (a == LCRAM_REG_CONFIG)
			{regout_m, async_m, arr_m} <= d[3:0];
		if (a == LCRAM_REG_TRUTH)
			truth_m <= d;
	endtask
	task automatic reg_rd(input logic [1:0] a, output logic [31:0] v);
		@(posedge clock);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clock);
		reg_read <= 1'b0;
		@(negedge clock);
		v = reg_rdata;
	endtask
	// random pins, both addresses equal in each word where seed bit 3 is set
	task automatic traffic(input int n);
		for (int i = 0; i < n; i++) begin
			@(posedge clock);
			seed = xs(seed);
			next_pins <= seed[3] ? {seed[14:11], seed[14:11], seed[2:0]} : seed[10:0];
			@(negedge clock);
			check(32'(fd), 32'(exp_first()));
			check(32'(sd), 32'(exp_second()));
			// cell flops show last cycle's outputs while enabled, else their reset zero
			if (i > 0) begin
				check(32'(fq), 32'(regout_m && pf));
				check(32'(sq), 32'(regout_m && ps));
			end
			pf = exp_first();
			ps = exp_second();
		end
	endtask
	initial begin
		repeat (20) @(posedge clock);
		reset <= 1'b0;
		reg_rd(LCRAM_REG_TRUTH, rv);
		check(rv, 32'h0000_0000);
		reg_rd(2'h3, rv);
		check(rv, 32'h0000_0000);
		for (int k = 0; k < 8; k++) begin
			// mid-run reset: both tables start equal, so the dual read ports agree
			@(posedge clock);
			reset <= 1'b1;
			next_pins <= 11'h000;
			{regout_m, async_m, arr_m} <= 4'h0;
			repeat (2) @(posedge clock);
			reset <= 1'b0;
			seed = xs(seed);
			reg_wr(LCRAM_REG_TRUTH, seed);
			reg_wr(LCRAM_REG_CONFIG, {28'h000_0000, k[0], k[2:0]});
			reg_rd(LCRAM_REG_CONFIG, rv);
			check(rv, {28'h000_0000, k[0], k[2:0]});
			traffic(250);
			reg_wr(LCRAM_REG_STATUS, 32'hffff_ffff);
			reg_rd(LCRAM_REG_STATUS, rv);
			check(32'(rv[2]), 32'(k[1:0] == 2'h2 && k[2]));
			$display("test %0d done", k);
		end
		stop_test();
	end
endmodule
